/* File: rtl/rcbc_pkg.sv */
package rcbc_pkg;
  // Clock ratio strap codes
  localparam logic [1:0] RatioCode8   = 2'h0;
  localparam logic [1:0] RatioCode32  = 2'h1;
  localparam logic [1:0] RatioCode16  = 2'h2;
  localparam logic [1:0] RatioCodeRsv = 2'h3;
  // Ratio values as multipliers
  localparam logic [5:0] Ratio8  = 6'h08;
  localparam logic [5:0] Ratio32 = 6'h20;
  localparam logic [5:0] Ratio16 = 6'h10;
  // Lock wait in input-clock cycles
  localparam int unsigned LockWaitCycles = 4096;
  // Running-reset control bit position
  localparam int unsigned RunRstEnBit = 0;
  // Reset value of PLL divider field; the multiplier resets to Ratio8
  localparam logic [5:0] PllDivReset = 6'h01;

  // Strap values caught at reset release
  typedef struct packed {
    logic [1:0] ratioCode;
    logic [2:0] bootCfg;
  } rcbc_straps_s;

  // Software PLL settings
  typedef struct packed {
    logic [5:0] mult;
    logic [5:0] div;
  } rcbc_pll_s;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_RESET = 3'b001,
    SEQ_LOCK  = 3'b010,
    SEQ_RUN   = 3'b100
  } rcbc_seq_e;
endpackage : rcbc_pkg

/* File: rtl/reset_clock_boot_config.sv */
module reset_clock_boot_config #(
  parameter int unsigned LOCK_CYCLES = rcbc_pkg::LockWaitCycles
) (
  input  wire logic                   clk,            // Input clock
  input  wire logic                   srst,           // Synchronous reset, high
  input  wire logic                   extResetN,      // External reset pin, low
  input  wire logic [1:0]             ratioStrap,     // Ratio strap pins
  input  wire logic [2:0]             bootStrap,      // Boot strap pins
  input  wire logic                   crystalPresent, // Crystal network sensed
  input  wire logic                   runRstCtlWr,    // Control write strobe
  input  wire logic                   runRstCtlData,  // Control bit 0 value
  input  wire logic                   pmCtlWr,        // PLL control write strobe
  input  wire rcbc_pkg::rcbc_pll_s    pmCtlData,      // PLL write data
  input  wire logic                   sharedPinIn,    // Shared pin input level
  output logic                        sharedPinOut,   // Shared pin drive level
  output logic                        sharedPinOe,    // Shared pin drive enable
  output logic                        coreResetN,     // Core held while low
  output logic                        coreRun,        // Core executing from vector
  output logic [5:0]                  coreRatio,      // Active clock ratio
  output logic                        ratioReserved,  // Reserved ratio strapped
  output logic [2:0]                  bootMode,       // Selected boot mode
  output rcbc_pkg::rcbc_pll_s         power_mgmt_control,          // Power management control
  output logic                        useCrystalOsc,  // Internal oscillator on
  output logic                        runResetReq     // Running reset seen
);
  import rcbc_pkg::*;

  localparam int CW = $clog2(LOCK_CYCLES + 1);
  localparam int SW = $bits(rcbc_straps_s) + 1;  // Straps plus crystal sense

  // Three-stage synchronisers for pin inputs
  logic [2:0] rstSync_q,  rstSync_d;   // External reset pipeline
  logic [2:0] runSync_q,  runSync_d;   // Running reset pipeline
  logic       rstLvl_q,   rstLvl_d;    // Accepted reset level (low active)
  logic       runLvl_q,   runLvl_d;    // Accepted running-reset level
  logic [SW-1:0] strapS1_q,  strapS1_d;  // Strap pins, first stage
  logic [SW-1:0] strapS2_q,  strapS2_d;  // Strap pins, second stage
  logic [SW-1:0] strapS3_q,  strapS3_d;  // Strap pins, third stage
  logic [SW-1:0] strapLvl_q, strapLvl_d; // Accepted strap levels

  // Sequencer state
  rcbc_seq_e    state_q, state_d;      // Sequencer state
  logic [CW-1:0] cnt_q, cnt_d;         // Lock wait counter
  rcbc_straps_s straps_q, straps_d;    // Captured straps
  rcbc_pll_s    pll_q, pll_d;          // PLL settings
  logic         runEn_q, runEn_d;      // Running-reset enable
  logic         crystal_terminal_q, crystal_terminal_d;        // Oscillator select
  logic         runReq_q, runReq_d;    // Running reset request, held while pin low
  logic [5:0]   ratio_d;               // Decoded ratio
  logic         pinOut_d;              // Shared pin level next
  logic         pinOe_d;               // Shared pin drive enable next
  logic         running_d;             // Core released next
  logic         ratioRsv_d;            // Reserved strap code next

  // Synchroniser next values; change counts when stages 2 and 3 agree
  always_comb begin
    rstSync_d = {rstSync_q[1:0], extResetN};
    runSync_d = {runSync_q[1:0], sharedPinIn};
    rstLvl_d  = (rstSync_q[2] == rstSync_q[1]) ? rstSync_q[2] : rstLvl_q;
    runLvl_d  = (runSync_q[2] == runSync_q[1]) ? runSync_q[2] : runLvl_q;
    // Strap pins are board levels too, so they pass the same filter
    strapS1_d  = {ratioStrap, bootStrap, crystalPresent};
    strapS2_d  = strapS1_q;
    strapS3_d  = strapS2_q;
    strapLvl_d = (strapS3_q == strapS2_q) ? strapS3_q : strapLvl_q;
  end

  // Synchroniser registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rstSync_q <= 3'h0;
      runSync_q <= 3'h7;
      rstLvl_q  <= 1'h0;
      runLvl_q  <= 1'h1;
      strapS1_q  <= '0;
      strapS2_q  <= '0;
      strapS3_q  <= '0;
      strapLvl_q <= '0;
    end else begin
      rstSync_q <= rstSync_d;
      runSync_q <= runSync_d;
      rstLvl_q  <= rstLvl_d;
      runLvl_q  <= runLvl_d;
      strapS1_q  <= strapS1_d;
      strapS2_q  <= strapS2_d;
      strapS3_q  <= strapS3_d;
      strapLvl_q <= strapLvl_d;
    end
  end

  // Ratio decode of the captured straps
  always_comb begin
    case (straps_q.ratioCode)
      RatioCode8:  ratio_d = Ratio8;
      RatioCode32: ratio_d = Ratio32;
      RatioCode16: ratio_d = Ratio16;
      default:     ratio_d = Ratio8;                        // Reserved: safe slowest
    endcase
  end

  // Sequencer next state
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    straps_d = straps_q;
    pll_d    = pll_q;
    runEn_d  = runEn_q;
    crystal_terminal_d   = crystal_terminal_q;
    runReq_d = 1'h0;
    case (state_q)
      SEQ_RESET: begin
        // Pin low holds everything; board drives it at power-up
        cnt_d   = '0;
        runEn_d = 1'h0;
        pll_d   = '{mult: Ratio8, div: PllDivReset};
        if (rstLvl_q) begin
          // Filtered straps and crystal sense caught once, at release
          {straps_d, crystal_terminal_d} = strapLvl_q;
          state_d  = SEQ_LOCK;
        end
      end
      SEQ_LOCK: begin
        if (cnt_q == CW'(LOCK_CYCLES - 1)) begin
          state_d = SEQ_RUN;
          pll_d   = '{mult: ratio_d, div: PllDivReset};
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      SEQ_RUN: begin
        if (pmCtlWr) begin
          pll_d = pmCtlData;
        end
        if (runRstCtlWr) begin
          runEn_d = runRstCtlData;
        end
        runReq_d = runEn_q && !runLvl_q;
      end
      default: state_d = SEQ_RESET;
    endcase
    if (!rstLvl_q) begin
      state_d = SEQ_RESET;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q  <= SEQ_RESET;
      cnt_q    <= '0;
      straps_q <= '0;
      pll_q    <= '{mult: Ratio8, div: PllDivReset};
      runEn_q  <= 1'h0;
      crystal_terminal_q   <= 1'h0;
      runReq_q <= 1'h0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      straps_q <= straps_d;
      pll_q    <= pll_d;
      runEn_q  <= runEn_d;
      crystal_terminal_q   <= crystal_terminal_d;
      runReq_q <= runReq_d;
    end
  end

  // Output next values, so the output registers only copy
  always_comb begin
    pinOut_d   = (state_d == SEQ_RUN);
    pinOe_d    = !runEn_d;
    running_d  = (state_d == SEQ_RUN);
    ratioRsv_d = (straps_q.ratioCode == RatioCodeRsv);
  end

  // Output registers
  always_ff @(posedge clk) begin
    if (srst) begin
      sharedPinOut  <= 1'h0;
      sharedPinOe   <= 1'h1;
      coreResetN    <= 1'h0;
      coreRun       <= 1'h0;
      coreRatio     <= Ratio8;
      ratioReserved <= 1'h0;
      bootMode      <= 3'h0;
      power_mgmt_control         <= '{mult: Ratio8, div: PllDivReset};
      useCrystalOsc <= 1'h0;
      runResetReq   <= 1'h0;
    end else begin
      sharedPinOut  <= pinOut_d;
      sharedPinOe   <= pinOe_d;
      coreResetN    <= running_d;
      coreRun       <= running_d;
      coreRatio     <= ratio_d;
      ratioReserved <= ratioRsv_d;
      bootMode      <= straps_q.bootCfg;
      power_mgmt_control         <= pll_d;
      useCrystalOsc <= crystal_terminal_d;
      runResetReq   <= runReq_q;
    end
  end

  // Named steps of the lock wait: accepted release, then a spent count
  sequence s_lock_entry;
    (state_q == SEQ_RESET) && rstLvl_q;
  endsequence
  sequence s_lock_done;
    (state_q == SEQ_LOCK) && (cnt_q == CW'(LOCK_CYCLES - 1)) && rstLvl_q;
  endsequence

  // Accepted release starts the wait from a zero count
  a_lock_entry: assert property (@(posedge clk) disable iff (srst)
    s_lock_entry |=> ((state_q == SEQ_LOCK) && (cnt_q == '0)))
    else $error("lock wait did not start from zero");
  // Core never leaves reset before the full lock wait
  a_lock_wait_hold: assert property (@(posedge clk) disable iff (srst)
    (state_q == SEQ_LOCK && cnt_q < CW'(LOCK_CYCLES - 1)) |=> !coreResetN)
    else $error("core released before lock wait ended");
  // Lock end releases and runs the core at the next edge
  a_lock_release: assert property (@(posedge clk) disable iff (srst)
    s_lock_done |=> (coreResetN && coreRun))
    else $error("core not released after lock wait");
  // Straps steady outside reset
  a_straps_hold: assert property (@(posedge clk) disable iff (srst)
    (state_q != SEQ_RESET) |=> $stable(straps_q))
    else $error("straps changed after capture");
  // In reset the shared pin is driven low as reset output
  a_pin_default: assert property (@(posedge clk) disable iff (srst)
    (state_q == SEQ_RESET) |=> (sharedPinOe && !sharedPinOut))
    else $error("shared pin not driven while output");
  // Setting control bit releases the pin
  a_pin_input: assert property (@(posedge clk) disable iff (srst)
    (state_q == SEQ_RUN && rstLvl_q && runRstCtlWr && runRstCtlData) |=> !sharedPinOe)
    else $error("shared pin still driven in input mode");
  // A low pin in input mode raises the request two edges on
  a_run_reset_req: assert property (@(posedge clk) disable iff (srst)
    (state_q == SEQ_RUN && runEn_q && !runLvl_q) |=> ##1 runResetReq)
    else $error("running reset not reported");
  // While the pin is an output no running reset is reported
  a_no_req_output: assert property (@(posedge clk) disable iff (srst)
    !runEn_q |=> ##1 !runResetReq)
    else $error("running reset reported in output mode");
  // PLL write lands when running
  a_pll_write: assert property (@(posedge clk) disable iff (srst)
    (state_q == SEQ_RUN && rstLvl_q && pmCtlWr) |=> (power_mgmt_control == $past(pmCtlData)))
    else $error("PLL write not applied");
  // Ratio decode
  a_ratio_map: assert property (@(posedge clk) disable iff (srst)
    (straps_q.ratioCode == RatioCode32) |=> (coreRatio == Ratio32))
    else $error("ratio decode wrong");
  // Boot mode follows captured straps
  a_boot_mode: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> (bootMode == $past(straps_q.bootCfg)))
    else $error("boot mode mismatch");
endmodule : reset_clock_boot_config

/* File: testbench/rcbc_board_model.sv */
// Board side: reset source, strap resistors and the shared pin's pull-up
module rcbc_board_model (
  input  wire logic       holdReset,    // Board holds reset asserted
  input  wire logic [1:0] ratioSet,     // Ratio strap levels
  input  wire logic [2:0] bootSet,      // Boot strap levels
  input  wire logic       xtalSet,      // Crystal network fitted
  input  wire logic       pullLow,      // Board pulls shared pin low
  input  wire logic       sharedPinOut, // Device drive level
  input  wire logic       sharedPinOe,  // Device drive enable
  output logic            extResetN,    // Reset pin, low active
  output logic [1:0]      ratioStrap,   // Ratio straps at pins
  output logic [2:0]      bootStrap,    // Boot straps at pins
  output logic            crystalPresent, // Crystal sense
  output logic            sharedPinIn   // Resolved shared pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Reset pin follows the board source
  assign extResetN = ~holdReset;
  // Straps are steady resistor levels
  assign ratioStrap = ratioSet;
  assign bootStrap = bootSet;
  assign crystalPresent = xtalSet;
  // Device drive wins; otherwise board pull-down, else pull-up
  assign sharedPinIn = sharedPinOe ? sharedPinOut : ~pullLow;
endmodule : rcbc_board_model

/* File: testbench/reset_clock_boot_config_tb_top.sv */
module reset_clock_boot_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rcbc_pkg::*;
  localparam int unsigned Lock = 16; // Shortened lock wait
  logic       clk, srst, holdReset, xtalSet, pullLow, runRstCtlWr, runRstCtlData, pmCtlWr;
  logic       extResetN, crystalPresent, sharedPinIn, sharedPinOut, sharedPinOe;
  logic       coreResetN, coreRun, ratioReserved, useCrystalOsc, runResetReq;
  logic [1:0] ratioSet, ratioStrap;
  logic [2:0] bootSet, bootStrap, bootMode;
  logic [5:0] coreRatio;
  rcbc_pll_s  pmCtlData, power_mgmt_control;
  int         err_count, checked, n;
  // Row: straps, crystal, expected ratio and reserved flag
  typedef struct packed {
    logic [1:0] r; // Ratio strap code
    logic [2:0] b; // Boot strap code
    logic       x; // Crystal fitted
    logic [5:0] q; // Expected ratio
    logic       v; // Expected reserved flag
  } rcbc_row_s;
  rcbc_row_s  rows [4];
  reset_clock_boot_config #(.LOCK_CYCLES(Lock)) u_dut (.clk(clk), .srst(srst),
    .extResetN(extResetN), .ratioStrap(ratioStrap), .bootStrap(bootStrap),
    .crystalPresent(crystalPresent), .runRstCtlWr(runRstCtlWr), .runRstCtlData(runRstCtlData),
    .pmCtlWr(pmCtlWr), .pmCtlData(pmCtlData), .sharedPinIn(sharedPinIn),
    .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe), .coreResetN(coreResetN),
    .coreRun(coreRun), .coreRatio(coreRatio), .ratioReserved(ratioReserved),
    .bootMode(bootMode), .power_mgmt_control(power_mgmt_control), .useCrystalOsc(useCrystalOsc),
    .runResetReq(runResetReq));
  rcbc_board_model u_board (.holdReset(holdReset), .ratioSet(ratioSet), .bootSet(bootSet),
    .xtalSet(xtalSet), .pullLow(pullLow), .sharedPinOut(sharedPinOut),
    .sharedPinOe(sharedPinOe), .extResetN(extResetN), .ratioStrap(ratioStrap),
    .bootStrap(bootStrap), .crystalPresent(crystalPresent), .sharedPinIn(sharedPinIn));
  // Free-running input clock, never halted
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count and report one comparison
  task automatic chkVec(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkVec
  // Print counts and verdict, then stop
  task automatic print_verdict;
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // Hold reset with new straps, release, count cycles until the core runs
  task automatic boot(input rcbc_row_s w, input logic wrInLock);
    @(negedge clk);
    {ratioSet, bootSet, xtalSet} = {w.r, w.b, w.x};
    @(negedge clk);
    holdReset = 1'b1;
    repeat (6) @(negedge clk);
    chkVec({coreResetN, sharedPinOe, sharedPinOut}, 12'h2);
    holdReset = 1'b0;
    n = 0;
    while (coreResetN !== 1'b1) begin
      @(negedge clk);
      n++;
      pmCtlWr = wrInLock && n == 8; // Refused write while locking
      if (n > 200) begin
        err_count++;
        $display("Error at %0t: core never started", $time);
        print_verdict();
      end
    end
    chkVec(12'(n > Lock && n <= Lock + 8), 12'h1);
    chkVec({coreRun, sharedPinOe, sharedPinOut}, 12'h7);
    chkVec({coreRatio, ratioReserved}, {w.q, w.v});
    chkVec({bootMode, useCrystalOsc}, {w.b, w.x});
    chkVec(power_mgmt_control, {w.q, PllDivReset});
  endtask : boot
  // Main sequence
  initial begin
    {srst, holdReset} = 2'b11;
    {xtalSet, pullLow, runRstCtlWr, runRstCtlData, pmCtlWr} = '0;
    {ratioSet, bootSet, pmCtlData, err_count, checked} = '0;
    rows[0] = {RatioCode8, 3'h5, 1'b1, Ratio8, 1'b0};
    rows[1] = {RatioCode32, 3'h2, 1'b0, Ratio32, 1'b0};
    rows[2] = {RatioCode16, 3'h7, 1'b1, Ratio16, 1'b0};
    rows[3] = {RatioCodeRsv, 3'h0, 1'b0, Ratio8, 1'b1};
    repeat (12) @(negedge clk);
    srst = 1'b0;
    foreach (rows[i]) boot(rows[i], 1'b0);
    boot(rows[1], 1'b1);
    // Back-to-back PLL writes in run, last one stays
    pmCtlWr = 1'b1;
    pmCtlData = {6'h0c, 6'h02};
    @(negedge clk);
    pmCtlData = {6'h14, 6'h03};
    @(negedge clk);
    pmCtlWr = 1'b0;
    @(negedge clk);
    chkVec(power_mgmt_control, {6'h14, 6'h03});
    // Straps moved in run must not disturb captured values
    {ratioSet, bootSet, xtalSet} = {RatioCode16, 3'h6, 1'b1};
    repeat (8) @(negedge clk);
    chkVec({coreRatio, bootMode, useCrystalOsc}, {Ratio32, 3'h2, 1'b0});
    // Low pin while still a reset output raises no request
    pullLow = 1'b1;
    repeat (6) @(negedge clk);
    chkVec({runResetReq, sharedPinOe}, 12'h1);
    // Switch the pin to running-reset input
    {runRstCtlWr, runRstCtlData} = 2'b11;
    @(negedge clk);
    runRstCtlWr = 1'b0;
    repeat (8) @(negedge clk);
    chkVec({sharedPinOe, runResetReq}, 12'h1);
    pullLow = 1'b0;
    repeat (8) @(negedge clk);
    chkVec(runResetReq, 12'h0);
    // Clearing the bit hands the pin back to reset output
    {runRstCtlWr, runRstCtlData} = 2'b10;
    @(negedge clk);
    runRstCtlWr = 1'b0;
    @(negedge clk);
    chkVec({sharedPinOe, sharedPinOut, runResetReq}, 12'h6);
    // Input mode left set is cleared by the next external reset
    {runRstCtlWr, runRstCtlData} = 2'b11;
    @(negedge clk);
    runRstCtlWr = 1'b0;
    @(negedge clk);
    chkVec(sharedPinOe, 12'h0);
    boot(rows[2], 1'b0);
    print_verdict();
  end
endmodule : reset_clock_boot_config_tb_top
